// ### dmcp_pkg.sv
// Purpose: Shared constants and types for the dual-mode control port.
// Assumes: One system clock; all pin-side signals are synchronised inside the port.
// Notes:   Register offsets are seven-bit pointer values.
`default_nettype none
package dmcp_pkg;

    // Chip addressing.
    localparam logic [6:0] SPI_CHIP_ADDR = 7'h10;
    localparam logic [3:0] I2C_ADDR_HI   = 4'h2;

    // Pointer byte layout.
    localparam int         PTR_STEP_BIT  = 7;
    localparam logic [7:0] PTR_RST       = 8'h00;

    // Register offsets.
    localparam logic [6:0] REG_CTRL1     = 7'h01;
    localparam logic [6:0] REG_IRQ1_STAT = 7'h07;
    localparam logic [6:0] REG_IRQ2_STAT = 7'h08;
    localparam logic [6:0] REG_IRQ1_MASK = 7'h09;
    localparam logic [6:0] REG_IRQ1_MDHI = 7'h0A;
    localparam logic [6:0] REG_IRQ1_MDLO = 7'h0B;
    localparam logic [6:0] REG_IRQ2_MASK = 7'h0C;
    localparam logic [6:0] REG_IRQ2_MDHI = 7'h0D;
    localparam logic [6:0] REG_IRQ2_MDLO = 7'h0E;
    localparam logic [6:0] REG_ID        = 7'h7F;
    localparam logic [7:0] REG_RST       = 8'h00;
    localparam int         REG_DEPTH     = 128;

    // Field positions: pin style in control 1, sources in the status registers.
    localparam int         STYLE_LSB     = 1;
    localparam int         BIT_SLIP      = 7;
    localparam int         BIT_CS_DONE   = 1;
    localparam int         BIT_UD_DONE   = 2;
    localparam int         IRQ_N         = 3;

    // Source sensitivity and pin style encodings.
    localparam logic [1:0] MODE_RISE     = 2'h0;
    localparam logic [1:0] MODE_FALL     = 2'h1;
    localparam logic [1:0] MODE_LEVEL    = 2'h2;
    localparam logic [1:0] STYLE_HIGH    = 2'h0;
    localparam logic [1:0] STYLE_LOW     = 2'h1;
    localparam logic [1:0] STYLE_OD      = 2'h2;

    // Pin synchroniser reset level and slot of each pin in the sync vector.
    localparam logic [4:0] PIN_RST       = 5'h1F;
    localparam int         PIN_SEL       = 0;
    localparam int         PIN_CLK       = 1;
    localparam int         PIN_DIN       = 2;
    localparam int         PIN_A1        = 3;
    localparam int         PIN_A2        = 4;

    typedef enum {
        DMCP_ST_IDLE,
        DMCP_ST_ADDR,
        DMCP_ST_PTR,
        DMCP_ST_WDATA,
        DMCP_ST_RDATA,
        DMCP_ST_SKIP
    } dmcp_state_e;

    // Register write seen by the rest of the device.
    typedef struct packed {
        logic       stb;
        logic [6:0] addr;
        logic [7:0] data;
    } dmcp_wr_s;

    // Interrupt configuration taken from the register file.
    typedef struct packed {
        logic [IRQ_N-1:0] mask;
        logic [IRQ_N-1:0] mode_hi;
        logic [IRQ_N-1:0] mode_lo;
        logic [1:0]       style;
    } dmcp_irq_cfg_s;

endpackage
`default_nettype wire

// ### dmcp_irq.sv
// Purpose: Sticky interrupt status, masking and interrupt pin styling.
// Assumes: Sources come from logic on CLK; clear pulses come from status reads.
// Notes:   A source event in the clearing cycle keeps its bit set.
`timescale 1ns/1ps
`default_nettype none
module dmcp_irq
    import dmcp_pkg::*;
(
    // Clock and reset.
    input  wire logic          CLK,
    input  wire logic          SRST,
    // Sources, clears and configuration.
    input  wire logic [IRQ_N-1:0] SRC,
    input  wire logic [IRQ_N-1:0] CLR,
    input  wire dmcp_irq_cfg_s CFG,
    // Status and pin.
    output logic [IRQ_N-1:0]   STATUS,
    output logic               INT_O,
    output logic               INT_OE
);
    logic [IRQ_N-1:0] prev_ff;
    logic [IRQ_N-1:0] stat_ff;
    logic [IRQ_N-1:0] nxt_stat;
    logic             any_irq;

    // Per-source detection; the set term is ORed last so it beats a clear.
    genvar g;
    generate
        for (g = 0; g < IRQ_N; g = g + 1)
        begin : g_src
            logic       hit;
            logic [1:0] mode;
            assign mode = {CFG.mode_hi[g], CFG.mode_lo[g]};
            always_comb
            begin
                case (mode)
                    MODE_RISE:  hit = SRC[g] & ~prev_ff[g];
                    MODE_FALL:  hit = ~SRC[g] & prev_ff[g];
                    MODE_LEVEL: hit = SRC[g];
                    default:    hit = 1'b0;
                endcase
                nxt_stat[g] = (stat_ff[g] & ~CLR[g]) | hit;
            end
        end
    endgenerate

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            prev_ff <= '0;
            stat_ff <= '0;
        end
        else
        begin
            prev_ff <= SRC;
            stat_ff <= nxt_stat;
        end
    end

    // Only unmasked status reaches the pin; the open-drain style only pulls low.
    assign any_irq = |(stat_ff & CFG.mask);
    always_comb
    begin
        case (CFG.style)
            STYLE_LOW:
            begin
                INT_O  = ~any_irq;
                INT_OE = 1'b1;
            end
            STYLE_OD:
            begin
                INT_O  = 1'b0;
                INT_OE = any_irq;
            end
            default:
            begin
                INT_O  = any_irq;
                INT_OE = 1'b1;
            end
        endcase
    end
    assign STATUS = stat_ff;

endmodule
`default_nettype wire

// ### dmcp_port.sv
// Purpose: Serial control port slave, four-wire or two-wire, with register file.
// Assumes: Bit clock far slower than CLK (32 ns period or more); pins are asynchronous.
// Notes:   Two-wire data pin, and interrupt pin in open-drain style, are open-drain via output enables.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - A falling select pin after reset switches the port to four-wire mode.
// - Four-wire input sampled on bit clock rise, output changes on its fall.
// - Write: byte after address loads pointer, next byte written; MSB first.
// - Four-wire serial output stays undriven throughout a write.
// - Pointer stays put unless its step bit is set; then it advances per byte.
// - First bit clock fall after a four-wire read address drives the pointed MSB.
// - Two-wire address is 0010 followed by the three address pin levels.
// - Two-wire write: first byte loads pointer, later bytes write registers.
// - Two-wire read returns pointed register, consecutive ones with stepping.
// - Two-wire: device acknowledges bytes received, host acknowledges bytes sent.
// - Interrupt pin is active high, active low, or open-drain active low.
// - Each interrupt source has a mask bit that keeps it off the pin.
// - Each source is rising edge, falling edge or level sensitive.
// - Port works with no timing relation to audio clocks.
// - Port reaches channel-status and user-data storage as well as registers.
// - Pointer byte: bit 7 step enable, bits 6..0 address; step off at reset.
// - Pin style 00 active high, 01 active low, 10 open-drain, 11 reserved.
module dmcp_port
    import dmcp_pkg::*;
#(
    parameter logic [7:0] ID_VERSION = 8'h5A   // Arbitrary identity value.
)
(
    // Clock and reset.
    input  wire logic             CLK,
    input  wire logic             SRST,
    // Control pins.
    input  wire logic             SELECT_OR_ADDR0_PIN,
    input  wire logic             ADDR1_PIN,
    input  wire logic             ADDR2_PIN,
    input  wire logic             CTRL_BIT_CLOCK,
    input  wire logic             CTRL_SERIAL_IN_I,
    output logic                  CTRL_SERIAL_IN_O,
    output logic                  CTRL_SERIAL_IN_OE,
    output logic                  CTRL_SERIAL_OUT_O,
    output logic                  CTRL_SERIAL_OUT_OE,
    // Interrupt pin.
    output logic                  INT_O,
    output logic                  INT_OE,
    // Device side.
    input  wire logic [IRQ_N-1:0] IRQ_SRC,
    output dmcp_wr_s              REG_WR,
    output logic                  SPI_MODE
);
    logic [4:0]    sync1_ff;
    logic [4:0]    sync2_ff;
    logic [4:0]    prev_ff;
    logic          spi_mode_ff,  nxt_spi_mode;
    dmcp_state_e   state_ff,     nxt_state;
    logic [2:0]    bit_cnt_ff,   nxt_bit_cnt;
    logic [7:0]    rx_ff,        nxt_rx;
    logic [7:0]    tx_ff,        nxt_tx;
    logic [7:0]    ptr_ff,       nxt_ptr;
    logic          ack_ff,       nxt_ack;
    logic          done_ff,      nxt_done;
    logic          drv_ack_ff,   nxt_drv_ack;
    logic          tx_act_ff,    nxt_tx_act;
    dmcp_wr_s      wr_ff,        nxt_wr;
    logic [7:0]    mem_ff [0:REG_DEPTH-1];
    logic          sel_fall, sel_rise, clk_rise, clk_fall, din_fall, din_rise;
    logic          start_evt, stop_evt, din;
    logic [7:0]    byte_in, rd_data;
    logic [6:0]    dev_addr;
    logic [IRQ_N-1:0] stat, clr;
    dmcp_irq_cfg_s irq_cfg;

    // Every pin crosses two flops first, since the host clocks on its own.
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sync1_ff <= PIN_RST;
            sync2_ff <= PIN_RST;
            prev_ff  <= PIN_RST;
        end
        else
        begin
            sync1_ff <= {ADDR2_PIN, ADDR1_PIN, CTRL_SERIAL_IN_I, CTRL_BIT_CLOCK,
                         SELECT_OR_ADDR0_PIN};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Edge detection looks only at the second stage and its delayed copy.
    assign sel_fall  = prev_ff[PIN_SEL] & ~sync2_ff[PIN_SEL];
    assign sel_rise  = ~prev_ff[PIN_SEL] & sync2_ff[PIN_SEL];
    assign clk_rise  = ~prev_ff[PIN_CLK] & sync2_ff[PIN_CLK];
    assign clk_fall  = prev_ff[PIN_CLK] & ~sync2_ff[PIN_CLK];
    assign din_fall  = prev_ff[PIN_DIN] & ~sync2_ff[PIN_DIN];
    assign din_rise  = ~prev_ff[PIN_DIN] & sync2_ff[PIN_DIN];
    assign din       = sync2_ff[PIN_DIN];
    assign byte_in   = {rx_ff[6:0], din};
    assign dev_addr  = {I2C_ADDR_HI, sync2_ff[PIN_A2], sync2_ff[PIN_A1],
                        sync2_ff[PIN_SEL]};
    // Two-wire framing: data moves while the clock is high.
    assign start_evt = sel_fall | (~spi_mode_ff & sync2_ff[PIN_CLK] & din_fall);
    assign stop_evt  = spi_mode_ff ? sel_rise : (sync2_ff[PIN_CLK] & din_rise);

    // Read mux: status registers and identity come from live logic.
    always_comb
    begin
        case (ptr_ff[6:0])
            REG_IRQ1_STAT: rd_data = {stat[1], 5'h00, stat[0], 1'b0};
            REG_IRQ2_STAT: rd_data = {5'h00, stat[2], 2'h0};
            REG_ID:        rd_data = ID_VERSION;
            default:       rd_data = mem_ff[ptr_ff[6:0]];
        endcase
    end

    // Transaction engine shared by both modes.
    always_comb
    begin
        nxt_spi_mode = spi_mode_ff;
        nxt_state    = state_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_rx       = rx_ff;
        nxt_tx       = tx_ff;
        nxt_ptr      = ptr_ff;
        nxt_ack      = ack_ff;
        nxt_done     = done_ff;
        nxt_drv_ack  = drv_ack_ff;
        nxt_tx_act   = tx_act_ff;
        nxt_wr       = '0;
        clr          = '0;
        if (sel_fall)
            nxt_spi_mode = 1'b1;
        if (stop_evt)
        begin
            nxt_state  = DMCP_ST_IDLE;
            nxt_ack    = 1'b0;
            nxt_done   = 1'b0;
            nxt_tx_act = 1'b0;
        end
        else if (start_evt)
        begin
            nxt_state   = DMCP_ST_ADDR;
            nxt_bit_cnt = 3'h0;
            nxt_ack     = 1'b0;
            nxt_done    = 1'b0;
            nxt_tx_act  = 1'b0;
        end
        else if (state_ff != DMCP_ST_IDLE && state_ff != DMCP_ST_SKIP)
        begin
            if (clk_rise)
            begin
                if (ack_ff)
                begin
                    // A high level in the host's slot ends the read.
                    if (state_ff == DMCP_ST_RDATA && !drv_ack_ff && din)
                        nxt_state = DMCP_ST_SKIP;
                end
                else
                begin
                    nxt_rx      = byte_in;
                    nxt_bit_cnt = bit_cnt_ff + 3'h1;
                    if (bit_cnt_ff == 3'h7)
                    begin
                        nxt_done    = ~spi_mode_ff;
                        nxt_drv_ack = 1'b1;
                        case (state_ff)
                            DMCP_ST_ADDR:
                            begin
                                if (byte_in[7:1] == (spi_mode_ff ? SPI_CHIP_ADDR : dev_addr))
                                    nxt_state = byte_in[0] ? DMCP_ST_RDATA : DMCP_ST_PTR;
                                else
                                begin
                                    nxt_state = DMCP_ST_SKIP;
                                    nxt_done  = 1'b0;
                                end
                            end
                            DMCP_ST_PTR:
                            begin
                                nxt_ptr   = byte_in;
                                nxt_state = DMCP_ST_WDATA;
                            end
                            DMCP_ST_WDATA:
                            begin
                                // Status and identity bytes are not storage.
                                nxt_wr.stb  = ptr_ff[6:0] != REG_IRQ1_STAT &&
                                              ptr_ff[6:0] != REG_IRQ2_STAT &&
                                              ptr_ff[6:0] != REG_ID;
                                nxt_wr.addr = ptr_ff[6:0];
                                nxt_wr.data = byte_in;
                                if (ptr_ff[PTR_STEP_BIT])
                                    nxt_ptr = {ptr_ff[7], ptr_ff[6:0] + 7'h01};
                            end
                            DMCP_ST_RDATA: nxt_drv_ack = 1'b0;
                            default:       nxt_state = DMCP_ST_SKIP;
                        endcase
                    end
                end
            end
            else if (clk_fall)
            begin
                if (done_ff)
                begin
                    nxt_done   = 1'b0;
                    nxt_ack    = 1'b1;
                    nxt_tx_act = 1'b0;
                end
                else if (state_ff == DMCP_ST_RDATA &&
                         (ack_ff || (spi_mode_ff && bit_cnt_ff == 3'h0)))
                begin
                    // Fetch next byte; the pointer steps as each byte is read when its step bit is set.
                    nxt_ack    = 1'b0;
                    nxt_tx     = rd_data;
                    nxt_tx_act = 1'b1;
                    clr[0]     = ptr_ff[6:0] == REG_IRQ1_STAT;
                    clr[1]     = ptr_ff[6:0] == REG_IRQ1_STAT;
                    clr[2]     = ptr_ff[6:0] == REG_IRQ2_STAT;
                    if (ptr_ff[PTR_STEP_BIT])
                        nxt_ptr = {ptr_ff[7], ptr_ff[6:0] + 7'h01};
                end
                else if (ack_ff)
                    nxt_ack = 1'b0;
                else if (state_ff == DMCP_ST_RDATA)
                    nxt_tx = {tx_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            spi_mode_ff <= 1'b0;
            state_ff    <= DMCP_ST_IDLE;
            bit_cnt_ff  <= 3'h0;
            rx_ff       <= REG_RST;
            tx_ff       <= REG_RST;
            ptr_ff      <= PTR_RST;
            ack_ff      <= 1'b0;
            done_ff     <= 1'b0;
            drv_ack_ff  <= 1'b0;
            tx_act_ff   <= 1'b0;
            wr_ff       <= '0;
        end
        else
        begin
            spi_mode_ff <= nxt_spi_mode;
            state_ff    <= nxt_state;
            bit_cnt_ff  <= nxt_bit_cnt;
            rx_ff       <= nxt_rx;
            tx_ff       <= nxt_tx;
            ptr_ff      <= nxt_ptr;
            ack_ff      <= nxt_ack;
            done_ff     <= nxt_done;
            drv_ack_ff  <= nxt_drv_ack;
            tx_act_ff   <= nxt_tx_act;
            wr_ff       <= nxt_wr;
        end
    end

    // Register and buffer storage, written one cycle after the byte lands.
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            for (int i = 0; i < REG_DEPTH; i++)
                mem_ff[i] <= REG_RST;
        end
        else if (wr_ff.stb)
            mem_ff[wr_ff.addr] <= wr_ff.data;
    end

    // Four-wire output drives only while a read byte is loaded.
    assign CTRL_SERIAL_OUT_O  = tx_ff[7];
    assign CTRL_SERIAL_OUT_OE = spi_mode_ff && state_ff == DMCP_ST_RDATA && tx_act_ff;
    // Two-wire data is open-drain: only ever pulled low.
    assign CTRL_SERIAL_IN_O   = 1'b0;
    assign CTRL_SERIAL_IN_OE  = ~spi_mode_ff &&
                                ((ack_ff && drv_ack_ff) ||
                                 (state_ff == DMCP_ST_RDATA && tx_act_ff && !tx_ff[7]));
    assign REG_WR   = wr_ff;
    assign SPI_MODE = spi_mode_ff;

    // Interrupt configuration gathered from its registers.
    assign irq_cfg.mask    = {mem_ff[REG_IRQ2_MASK][BIT_UD_DONE], mem_ff[REG_IRQ1_MASK][BIT_SLIP],
                              mem_ff[REG_IRQ1_MASK][BIT_CS_DONE]};
    assign irq_cfg.mode_hi = {mem_ff[REG_IRQ2_MDHI][BIT_UD_DONE], mem_ff[REG_IRQ1_MDHI][BIT_SLIP],
                              mem_ff[REG_IRQ1_MDHI][BIT_CS_DONE]};
    assign irq_cfg.mode_lo = {mem_ff[REG_IRQ2_MDLO][BIT_UD_DONE], mem_ff[REG_IRQ1_MDLO][BIT_SLIP],
                              mem_ff[REG_IRQ1_MDLO][BIT_CS_DONE]};
    assign irq_cfg.style   = mem_ff[REG_CTRL1][STYLE_LSB+1:STYLE_LSB];

    dmcp_irq u_irq (
        .CLK    (CLK),
        .SRST   (SRST),
        .SRC    (IRQ_SRC),
        .CLR    (clr),
        .CFG    (irq_cfg),
        .STATUS (stat),
        .INT_O  (INT_O),
        .INT_OE (INT_OE)
    );

endmodule
`default_nettype wire

// ### dmcp_port_monitor.sv
// Purpose: Port-level checks for the control port.
// Assumes: Bound to dmcp_port; one clock domain.
// Notes:   Figures follow the two-flop pin synchronisers.
`timescale 1ns/1ps
`default_nettype none
module dmcp_port_monitor
    import dmcp_pkg::*;
(
    // Clock and reset.
    input wire logic     CLK,
    input wire logic     SRST,
    // Pins.
    input wire logic     SELECT_OR_ADDR0_PIN,
    input wire logic     CTRL_BIT_CLOCK,
    input wire logic     CTRL_SERIAL_OUT_O,
    input wire logic     CTRL_SERIAL_OUT_OE,
    input wire logic     INT_O,
    input wire logic     INT_OE,
    // Device side.
    input wire dmcp_wr_s REG_WR,
    input wire logic     SPI_MODE
);
    // Every check runs on the system clock and sleeps through reset.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    a_mode_cause: assert property ($rose(SPI_MODE) |-> !$past(SELECT_OR_ADDR0_PIN, 2))
        else $error("mode switched without a select fall");
    a_mode_stays: assert property (SPI_MODE |=> SPI_MODE)
        else $error("four-wire mode dropped");
    a_out_idle: assert property (SELECT_OR_ADDR0_PIN [*6] |-> !CTRL_SERIAL_OUT_OE)
        else $error("data out driven while deselected");
    // The host samples on the rise, so the bit must hold well past it.
    a_out_steady: assert property ($rose(CTRL_BIT_CLOCK) && CTRL_SERIAL_OUT_OE
        |=> $stable(CTRL_SERIAL_OUT_O) [*3]) else $error("data out moved near a rise");
    a_wr_pulse: assert property (REG_WR.stb |=> !REG_WR.stb)
        else $error("write strobe longer than one cycle");
    a_wr_on_rise: assert property (REG_WR.stb |-> $past(CTRL_BIT_CLOCK, 2))
        else $error("write not after a bit clock rise");
    a_wr_selected: assert property (REG_WR.stb && SPI_MODE
        |-> !$past(SELECT_OR_ADDR0_PIN, 3)) else $error("write outside a frame");
    a_int_reset: assert property ($past(SRST) |-> INT_OE && !INT_O)
        else $error("interrupt pin not idle after reset");
endmodule
bind dmcp_port dmcp_port_monitor u_mon (.CLK, .SRST, .SELECT_OR_ADDR0_PIN, .CTRL_BIT_CLOCK,
    .CTRL_SERIAL_OUT_O, .CTRL_SERIAL_OUT_OE, .INT_O, .INT_OE, .REG_WR, .SPI_MODE);
`default_nettype wire

// ### dmcp_host.sv
// Purpose: Host master model for the four-wire and two-wire control pins.
// Assumes: Bit clock idles low and stands still between frames.
// Notes:   One bit takes eight system clocks, 32 ns.
`timescale 1ns/1ps
`default_nettype none
module dmcp_host (
    // Pacing clock.
    input wire logic CLK,
    // Device data out and the wired two-wire data line.
    input wire logic SDO_O,
    input wire logic SDO_OE,
    input wire logic SDA,
    // Host pins.
    output var logic SEL_N,
    output var logic SCK,
    output var logic MOSI
);
    logic last_sdo = 1'b0;
    logic two_wire = 1'b0;
    // A released line shows the inverse of its last value, never a stale copy.
    // In two-wire mode the pulled-up shared data line is read instead.
    wire sdo_lvl = two_wire ? SDA : SDO_OE ? SDO_O : ~last_sdo;
    initial
    begin
        SEL_N = 1'b1;
        SCK = 1'b0;
        MOSI = 1'b0;
    end
    // Track the last driven level.
    always @(negedge CLK)
        if (SDO_OE)
            last_sdo <= SDO_O;
    // Select changes are padded so no bit edge sits near them.
    task automatic select(input logic lvl);
        repeat (4) @(negedge CLK);
        SEL_N = lvl;
        repeat (4) @(negedge CLK);
    endtask
    // One bit: data set on the fall, taken on the rise.
    task automatic bit1(input logic b, output logic r);
        MOSI = b;
        repeat (4) @(negedge CLK);
        SCK = 1'b1;
        repeat (4) @(negedge CLK);
        r = sdo_lvl;
        SCK = 1'b0;
    endtask
    // One byte each way, MSB first.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        @(negedge CLK);
        for (int i = 7; i >= 0; i--)
            bit1(tx[i], rx[i]);
    endtask
    // Two-wire start (from 1) or stop (from 0): data moves while the clock is high.
    task automatic cond(input logic from);
        @(negedge CLK);
        MOSI = from;
        repeat (4) @(negedge CLK);
        SCK = 1'b1;
        repeat (4) @(negedge CLK);
        MOSI = ~from;
        repeat (4) @(negedge CLK);
        SCK = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb_dual_mode_control_port.sv
// Purpose: Self-checking bench for the control port in four-wire, then two-wire mode.
// Assumes: Host model paces the pins; select stays high in two-wire mode.
// Notes:   Interrupt sources are driven directly on the system clock.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_mode_control_port;
    import dmcp_pkg::*;
    localparam logic [7:0] ID = 8'hC3; // Arbitrary identity value.
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [IRQ_N-1:0] irq = '0;
    logic [1:0] apin = '0;
    logic in_o, in_oe, out_o, out_oe, int_o, int_oe, spi_mode;
    wire sel_n, sck, mosi;
    wire sda = mosi & ~in_oe;
    dmcp_wr_s reg_wr;
    dmcp_wr_s wr_q[$];
    logic [7:0] r0, r1;
    int n_fail = 0;
    int cmp_count = 0;
    always #2 clk = ~clk;
    dmcp_port #(.ID_VERSION(ID)) DUT (.CLK(clk), .SRST(srst), .SELECT_OR_ADDR0_PIN(sel_n),
        .ADDR1_PIN(apin[0]), .ADDR2_PIN(apin[1]), .CTRL_BIT_CLOCK(sck), .CTRL_SERIAL_IN_I(sda),
        .CTRL_SERIAL_IN_O(in_o), .CTRL_SERIAL_IN_OE(in_oe), .CTRL_SERIAL_OUT_O(out_o),
        .CTRL_SERIAL_OUT_OE(out_oe), .INT_O(int_o), .INT_OE(int_oe), .IRQ_SRC(irq),
        .REG_WR(reg_wr), .SPI_MODE(spi_mode));
    dmcp_host u_host (.CLK(clk), .SDO_O(out_o), .SDO_OE(out_oe), .SDA(sda), .SEL_N(sel_n),
        .SCK(sck), .MOSI(mosi));
    // Collect every stored byte for later comparison.
    always @(posedge clk)
        if (reg_wr.stb === 1'b1)
            wr_q.push_back(reg_wr);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_wr(input logic [6:0] a, input logic [7:0] d);
        dmcp_wr_s w;
        w = '0;
        if (wr_q.size() > 0)
            w = wr_q.pop_front();
        chk("reg_wr", {1'b1, a, d}, w);
    endtask
    // The pin needs a few clocks through edge detection, status and styling.
    task automatic chk_int(input string what, input logic exp);
        for (int i = 0; i < 16 && int_o !== exp; i++)
            @(negedge clk);
        chk(what, exp, int_o);
    endtask
    // Chip address with write direction, pointer, then up to two data bytes.
    task automatic wr(input logic [7:0] ptr, input int n, input logic [7:0] d0, d1);
        logic [7:0] rx;
        wr_q.delete();
        u_host.select(1'b0);
        u_host.xfer({SPI_CHIP_ADDR, 1'b0}, rx);
        u_host.xfer(ptr, rx);
        if (n > 0)
            u_host.xfer(d0, rx);
        if (n > 1)
            u_host.xfer(d1, rx);
        u_host.select(1'b1);
    endtask
    // Pointer by partial write, then a two-byte read frame.
    task automatic rd(input logic [7:0] ptr);
        wr(ptr, 0, 8'h00, 8'h00);
        u_host.select(1'b0);
        u_host.xfer({SPI_CHIP_ADDR, 1'b1}, r0);
        u_host.xfer(8'h00, r0);
        u_host.xfer(8'h00, r1);
        u_host.select(1'b1);
    endtask
    // Two-wire frame: start, address, one or two bytes, stop; a read ACKs all but the last.
    task automatic tw(input logic rnw, input int n, input logic [7:0] b0, b1);
        logic a;
        wr_q.delete();
        u_host.cond(1'b1);
        u_host.xfer({I2C_ADDR_HI, apin, 1'b1, rnw}, r0);
        u_host.bit1(1'b1, a);
        chk("ack_adr", 0, a);
        u_host.xfer(rnw ? 8'hFF : b0, r0);
        u_host.bit1(!rnw || n < 2, a);
        chk("ack_b0", rnw && n < 2, a);
        if (n > 1)
        begin
            u_host.xfer(rnw ? 8'hFF : b1, r1);
            u_host.bit1(1'b1, a);
            chk("ack_b1", rnw, a);
        end
        u_host.cond(1'b0);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end
    // Main sequence: writes, reads, then the interrupt pin.
    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        chk("mode", 0, spi_mode);
        wr(8'h05, 1, 8'hAB, 8'h00);
        chk_wr(7'h05, 8'hAB);
        chk("mode", 1, spi_mode);
        wr(8'h82, 2, 8'h11, 8'h22);
        chk_wr(7'h02, 8'h11);
        chk_wr(7'h03, 8'h22);
        wr(8'h04, 2, 8'h33, 8'h44);
        chk_wr(7'h04, 8'h33);
        chk_wr(7'h04, 8'h44);
        rd(8'h82);
        chk("rd0", 8'h11, r0);
        chk("rd1", 8'h22, r1);
        rd(8'h05);
        chk("fix1", 8'hAB, r1);
        rd({1'b0, REG_ID});
        chk("id", ID, r0);
        @(negedge clk);
        irq[0] = 1'b1;
        @(negedge clk);
        irq[0] = 1'b0;
        repeat (8) @(negedge clk);
        chk_int("masked", 1'b0);
        wr({1'b0, REG_IRQ1_MASK}, 1, 8'h02, 8'h00);
        chk_int("high", 1'b1);
        wr({1'b0, REG_CTRL1}, 1, 8'h02, 8'h00);
        chk_int("low", 1'b0);
        wr({1'b0, REG_CTRL1}, 1, 8'h04, 8'h00);
        chk("od_on", 1, int_oe);
        rd({1'b0, REG_IRQ1_STAT});
        chk("stat", 8'h02, r0);
        chk("clr", 8'h00, r1);
        chk("od_off", 0, int_oe);
        wr({1'b0, REG_CTRL1}, 1, 8'h00, 8'h00);
        wr({1'b0, REG_IRQ1_MDLO}, 1, 8'h02, 8'h00);
        irq[0] = 1'b1;
        repeat (8) @(negedge clk);
        chk_int("no_rise", 1'b0);
        irq[0] = 1'b0;
        chk_int("fall", 1'b1);
        // Other sources: slip by its rising edge, user-data done held high in level mode.
        wr({1'b0, REG_IRQ2_MDHI}, 1, 8'h04, 8'h00);
        irq = 3'h6;
        @(negedge clk);
        irq = 3'h4;
        rd({1'b0, REG_IRQ1_STAT});
        chk("slip", 8'h82, r0);
        rd({1'b0, REG_IRQ2_STAT});
        chk("lvl", 8'h04, r1);
        irq = 3'h0;
        // Mid-run reset with select held high brings the port back in two-wire mode.
        @(negedge clk);
        srst = 1'b1;
        apin = 2'b10;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        u_host.two_wire = 1'b1;
        repeat (4) @(negedge clk);
        chk("mode2", 0, spi_mode);
        tw(1'b0, 2, 8'hA0, 8'h5C);
        chk_wr(7'h20, 8'h5C);
        tw(1'b0, 2, 8'hA1, 8'h6D);
        chk_wr(7'h21, 8'h6D);
        tw(1'b0, 1, 8'hA0, 8'h00);
        tw(1'b1, 2, 8'h00, 8'h00);
        chk("tw_rd0", 8'h5C, r0);
        chk("tw_rd1", 8'h6D, r1);
        chk("sda_o", 0, in_o);
        close_out();
    end
endmodule
`default_nettype wire
